// File: stack_mem_model.sv
`timescale 1ns/1ps
`default_nettype none
module stack_mem_model #(parameter logic [31:0] PF_CODE = 32'h0000_0007)
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic st_valid,
  input wire stack_push_pkg::store_req_t st_req,
  output logic st_ready,
  output logic st_page_fault,
  output logic [31:0] st_fault_code,
  input wire logic [3:0] stall,
  input wire logic pf_arm
);
  int n;
  logic [3:0] waited;
  logic [31:0] a [64];
  logic [31:0] d [64];
  logic w [64];
  // Accept only after the set stall, so a slow memory is exercised
  assign st_ready = st_valid && (waited >= stall);
  // Fault lines mean something only at accept; inverted elsewhere
  assign st_page_fault = st_ready ? pf_arm : !pf_arm;
  assign st_fault_code = st_ready ? PF_CODE : ~PF_CODE;
  // Stall counter and log of stores that did not fault
  always_ff @(posedge aclk)
  begin
    if (!aresetn || !st_valid || st_ready)
      waited <= 4'h0;
    else
      waited <= waited + 4'h1;
    if (!aresetn)
      n <= 0;
    else if (st_ready && !pf_arm)
    begin
      a[n] <= st_req.addr;
      d[n] <= st_req.data;
      w[n] <= st_req.dword;
      n <= n + 1;
    end
  end
endmodule : stack_mem_model
`default_nettype wire

// File: stack_push_execution_unit.sv
// The AXI4-Lite slave port and the address map were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module stack_push_execution_unit
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  input wire logic [7:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [7:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  output logic st_valid,
  input wire logic st_ready,
  output stack_push_pkg::store_req_t st_req,
  input wire logic st_page_fault,
  input wire logic [31:0] st_fault_code,
  output logic busy,
  output logic shutdown,
  output stack_push_pkg::fault_t fault
);

  // Byte-lane merge for register writes
  function automatic logic [31:0] merge_strb(input logic [31:0] old_val, input logic [31:0] new_val,
                                             input logic [3:0] strb);
    logic [31:0] res;
    res = old_val;
    for (int i = 0; i < 4; i++)
    begin
      if (strb[i])
      begin
        res[i*8 +: 8] = new_val[i*8 +: 8];
      end
    end
    merge_strb = res;
  endfunction : merge_strb

  // Pointer as seen by the stack address size
  function automatic logic [31:0] sp_view(input logic [31:0] p, input logic a32);
    sp_view = a32 ? p : {16'h0000, p[15:0]};
  endfunction : sp_view

  function automatic logic [31:0] step_size(input logic dword);
    step_size = dword ? stack_push_pkg::STEP_DWORD : stack_push_pkg::STEP_WORD;
  endfunction : step_size

  // Last byte of an access lies above the limit
  function automatic logic beyond_limit(input logic [31:0] addr, input logic [31:0] len,
                                        input logic [31:0] limit);
    logic [32:0] last;
    last = {1'b0, addr} + {1'b0, len} - {1'b0, stack_push_pkg::ONE_WORD};
    beyond_limit = last > {1'b0, limit};
  endfunction : beyond_limit

  function automatic logic is_mapped(input logic [7:0] a);
    is_mapped = (a[7:5] == stack_push_pkg::GPR_BANK_SEL) || (a <= stack_push_pkg::ERR_CODE_OFFSET);
  endfunction : is_mapped

  stack_push_pkg::ctrl_t ctrl;
  stack_push_pkg::exec_state_t state;
  logic [31:0] stack_ptr;
  logic [31:0] ss_limit;
  logic [31:0] ss_base;
  logic [31:0] src_value;
  logic [31:0] mem_disp;
  logic [31:0] mem_limit;
  logic [31:0] ea_out;
  logic [31:0] err_code;
  logic [31:0] gpr [8];
  logic [31:0] temp_sp;
  logic [31:0] work_ptr;
  logic [2:0] slot;
  logic done;

  // Write channel decode
  wire wr_fire = awvalid && wvalid && !bvalid;
  wire wr_mapped = is_mapped(awaddr);
  wire wr_gpr = awaddr[7:5] == stack_push_pkg::GPR_BANK_SEL;
  wire wr_idle = state == stack_push_pkg::ST_IDLE;
  wire [31:0] wr_ctrl_word = merge_strb(ctrl, wdata, wstrb);
  wire start_req = wr_fire && wr_idle && awaddr == stack_push_pkg::CTRL_OFFSET && wstrb[0] && wdata[0];
  wire rd_fire = arvalid && !rvalid;

  assign awready = wr_fire;
  assign wready = wr_fire;
  assign arready = !rvalid;
  assign busy = !wr_idle;

  // Instruction-level decode
  wire dword = ctrl.op32;
  wire a32 = ctrl.addr32;
  wire [31:0] step = step_size(dword);
  wire [31:0] start_view = sp_view(stack_ptr, a32);
  wire [31:0] work_view = sp_view(work_ptr, a32);
  wire is_real = ctrl.mode == stack_push_pkg::MODE_REAL;
  wire is_prot = ctrl.mode == stack_push_pkg::MODE_PROT;
  wire is_v86 = ctrl.mode == stack_push_pkg::MODE_V86;
  wire is_push_all = ctrl.kind == stack_push_pkg::OP_PUSH_ALL;
  wire is_mem = ctrl.kind == stack_push_pkg::OP_PUSH_MEM;

  // Pointer drop; a 16-bit stack touches only the low half, no realignment
  wire [31:0] new_ptr = a32 ? work_ptr - step : {work_ptr[31:16], work_view[15:0] - step[15:0]};
  wire [31:0] new_view = sp_view(new_ptr, a32);
  wire stack_overrun = beyond_limit(new_view, step, ss_limit);
  wire unaligned = dword ? (new_view[1:0] != 2'b00) : new_view[0];
  wire align_fault = ctrl.align_check_en && unaligned && (is_v86 || (is_prot && ctrl.cpl == stack_push_pkg::CPL_USER));

  // Real-mode stack exhaustion; caught before any store
  wire sp_is_one = start_view == stack_push_pkg::REAL_SHUTDOWN_SP_A;
  wire sp_odd_low = sp_is_one || start_view == stack_push_pkg::REAL_SHUTDOWN_SP_B ||
                    start_view == stack_push_pkg::REAL_SHUTDOWN_SP_C;
  wire exhausted = is_real && (is_push_all ? sp_odd_low : sp_is_one);

  // Flags pop exception tail; only the checks, no flag update here
  wire pop_gp = is_v86 && (ctrl.io_privilege_level < stack_push_pkg::IO_PRIVILEGE_LEVEL_FULL || ctrl.size_override);
  wire pop_ss = is_prot && beyond_limit(start_view, step, ss_limit);

  // Memory source operand checks
  wire mem_null = is_prot && ctrl.null_selector;
  wire mem_over = beyond_limit(ea_out, step, ctrl.mem_in_stack_seg ? ss_limit : mem_limit);

  // Store data; width follows operand size only
  wire [31:0] all_value = (slot == stack_push_pkg::SAVED_SP_SLOT) ? temp_sp : gpr[slot];
  wire [31:0] raw_value = is_push_all ? all_value :
                          (ctrl.kind == stack_push_pkg::OP_PUSH_SP) ? temp_sp : src_value;
  wire [31:0] store_value = dword ? raw_value : {16'h0000, raw_value[15:0]};

  // Register read mux
  wire [31:0] status_word = {25'h000_0000, fault, 1'b0, shutdown, done, busy};
  wire [31:0] read_word =
    (araddr[7:5] == stack_push_pkg::GPR_BANK_SEL) ? gpr[araddr[4:2]] :
    (araddr == stack_push_pkg::CTRL_OFFSET) ? {ctrl[31:1], 1'b0} :
    (araddr == stack_push_pkg::STATUS_OFFSET) ? status_word :
    (araddr == stack_push_pkg::STACK_PTR_OFFSET) ? stack_ptr :
    (araddr == stack_push_pkg::SS_LIMIT_OFFSET) ? ss_limit :
    (araddr == stack_push_pkg::SS_BASE_OFFSET) ? ss_base :
    (araddr == stack_push_pkg::SRC_VALUE_OFFSET) ? src_value :
    (araddr == stack_push_pkg::MEM_DISP_OFFSET) ? mem_disp :
    (araddr == stack_push_pkg::MEM_LIMIT_OFFSET) ? mem_limit :
    (araddr == stack_push_pkg::EA_OUT_OFFSET) ? ea_out :
    (araddr == stack_push_pkg::ERR_CODE_OFFSET) ? err_code : stack_push_pkg::ZERO_WORD;

  // Write response; unmapped offsets answer with an error
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      bvalid <= 1'b0;
      bresp <= stack_push_pkg::RESP_OKAY;
    end
    else if (ce)
    begin
      if (wr_fire)
      begin
        bvalid <= 1'b1;
        bresp <= wr_mapped ? stack_push_pkg::RESP_OKAY : stack_push_pkg::RESP_SLVERR;
      end
      else if (bready)
      begin
        bvalid <= 1'b0;
      end
    end
  end

  // Read data captured so rdata holds while rready is low
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rvalid <= 1'b0;
      rdata <= stack_push_pkg::ZERO_WORD;
      rresp <= stack_push_pkg::RESP_OKAY;
    end
    else if (ce)
    begin
      if (rd_fire)
      begin
        rvalid <= 1'b1;
        rdata <= read_word;
        rresp <= is_mapped(araddr) ? stack_push_pkg::RESP_OKAY : stack_push_pkg::RESP_SLVERR;
      end
      else if (rready)
      begin
        rvalid <= 1'b0;
      end
    end
  end

  // Operand registers; frozen while an instruction runs so the sequence sees stable inputs
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      ss_limit <= stack_push_pkg::LIMIT_RESET;
      ss_base <= stack_push_pkg::ZERO_WORD;
      src_value <= stack_push_pkg::ZERO_WORD;
      mem_disp <= stack_push_pkg::ZERO_WORD;
      mem_limit <= stack_push_pkg::LIMIT_RESET;
      for (int i = 0; i < 8; i++)
      begin
        gpr[i] <= stack_push_pkg::ZERO_WORD;
      end
    end
    else if (ce && wr_fire && wr_idle)
    begin
      if (wr_gpr)
      begin
        gpr[awaddr[4:2]] <= merge_strb(gpr[awaddr[4:2]], wdata, wstrb);
      end
      case (awaddr)
        stack_push_pkg::SS_LIMIT_OFFSET: ss_limit <= merge_strb(ss_limit, wdata, wstrb);
        stack_push_pkg::SS_BASE_OFFSET: ss_base <= merge_strb(ss_base, wdata, wstrb);
        stack_push_pkg::SRC_VALUE_OFFSET: src_value <= merge_strb(src_value, wdata, wstrb);
        stack_push_pkg::MEM_DISP_OFFSET: mem_disp <= merge_strb(mem_disp, wdata, wstrb);
        stack_push_pkg::MEM_LIMIT_OFFSET: mem_limit <= merge_strb(mem_limit, wdata, wstrb);
        default: ;
      endcase
    end
  end

  // Execution sequence
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      state <= stack_push_pkg::ST_IDLE;
      ctrl <= '0;
      stack_ptr <= stack_push_pkg::STACK_PTR_RESET;
      temp_sp <= stack_push_pkg::ZERO_WORD;
      work_ptr <= stack_push_pkg::ZERO_WORD;
      ea_out <= stack_push_pkg::ZERO_WORD;
      err_code <= stack_push_pkg::ZERO_WORD;
      slot <= 3'h0;
      done <= 1'b0;
      shutdown <= 1'b0;
      fault <= stack_push_pkg::FAULT_NONE;
      st_valid <= 1'b0;
      st_req <= '0;
    end
    else if (ce)
    begin
      case (state)
        stack_push_pkg::ST_IDLE:
        begin
          if (wr_fire && awaddr == stack_push_pkg::STACK_PTR_OFFSET)
          begin
            stack_ptr <= merge_strb(stack_ptr, wdata, wstrb);
          end
          if (wr_fire && awaddr == stack_push_pkg::CTRL_OFFSET)
          begin
            ctrl <= {wr_ctrl_word[31:1], 1'b0};
          end
          if (start_req)
          begin
            // Snapshot before any drop; reused for stack-pointer sources
            temp_sp <= sp_view(stack_ptr, wr_ctrl_word[5]);
            work_ptr <= stack_ptr;
            // Stack-based address uses the undecremented pointer
            ea_out <= mem_disp + (wr_ctrl_word[15] ? sp_view(stack_ptr, wr_ctrl_word[5]) : 32'h0000_0000);
            err_code <= stack_push_pkg::ZERO_WORD;
            slot <= 3'h0;
            done <= 1'b0;
            shutdown <= 1'b0;
            fault <= stack_push_pkg::FAULT_NONE;
            state <= stack_push_pkg::ST_CHECK;
          end
        end
        stack_push_pkg::ST_CHECK:
        begin
          state <= stack_push_pkg::ST_FINISH;
          if (ctrl.kind == stack_push_pkg::OP_FLAGS_POP)
          begin
            if (pop_gp)
            begin
              fault <= stack_push_pkg::FAULT_GP;
            end
            else if (pop_ss)
            begin
              fault <= stack_push_pkg::FAULT_SS;
            end
          end
          else if (exhausted)
          begin
            shutdown <= 1'b1;
          end
          else if (is_mem && mem_null)
          begin
            fault <= stack_push_pkg::FAULT_GP;
          end
          else if (is_mem && mem_over)
          begin
            fault <= ctrl.mem_in_stack_seg ? stack_push_pkg::FAULT_SS : stack_push_pkg::FAULT_GP;
          end
          else
          begin
            state <= stack_push_pkg::ST_STEP;
          end
        end
        stack_push_pkg::ST_STEP:
        begin
          if (stack_overrun)
          begin
            fault <= stack_push_pkg::FAULT_SS;
            state <= stack_push_pkg::ST_FINISH;
          end
          else if (align_fault)
          begin
            fault <= stack_push_pkg::FAULT_AC;
            state <= stack_push_pkg::ST_FINISH;
          end
          else
          begin
            // Pointer lowered, then the store goes out at the new top
            work_ptr <= new_ptr;
            st_req <= '{addr: ss_base + new_view, data: store_value, dword: dword};
            st_valid <= 1'b1;
            state <= stack_push_pkg::ST_WAIT;
          end
        end
        stack_push_pkg::ST_WAIT:
        begin
          if (st_ready)
          begin
            st_valid <= 1'b0;
            if (st_page_fault && !is_real)
            begin
              // Architectural pointer untouched on a faulting store
              fault <= stack_push_pkg::FAULT_PF;
              err_code <= st_fault_code;
              state <= stack_push_pkg::ST_FINISH;
            end
            else if (is_push_all && slot != stack_push_pkg::LAST_SLOT)
            begin
              slot <= slot + 3'h1;
              state <= stack_push_pkg::ST_STEP;
            end
            else
            begin
              stack_ptr <= work_ptr;
              state <= stack_push_pkg::ST_FINISH;
            end
          end
        end
        stack_push_pkg::ST_FINISH:
        begin
          // No flag register is written by any path
          done <= 1'b1;
          state <= stack_push_pkg::ST_IDLE;
        end
        default:
        begin
          state <= stack_push_pkg::ST_IDLE;
        end
      endcase
    end
  end

endmodule : stack_push_execution_unit
`default_nettype wire

// File: stack_push_pkg.sv
package stack_push_pkg;

  // Register byte offsets
  localparam logic [7:0] CTRL_OFFSET = 8'h00;
  localparam logic [7:0] STATUS_OFFSET = 8'h04;
  localparam logic [7:0] STACK_PTR_OFFSET = 8'h08;
  localparam logic [7:0] SS_LIMIT_OFFSET = 8'h0C;
  localparam logic [7:0] SS_BASE_OFFSET = 8'h10;
  localparam logic [7:0] SRC_VALUE_OFFSET = 8'h14;
  localparam logic [7:0] MEM_DISP_OFFSET = 8'h18;
  localparam logic [7:0] MEM_LIMIT_OFFSET = 8'h1C;
  localparam logic [7:0] EA_OUT_OFFSET = 8'h20;
  localparam logic [7:0] ERR_CODE_OFFSET = 8'h24;
  localparam logic [2:0] GPR_BANK_SEL = 3'h2;

  // Reset values
  localparam logic [31:0] STACK_PTR_RESET = 32'h0000_0000;
  localparam logic [31:0] LIMIT_RESET = 32'h0000_FFFF;
  localparam logic [31:0] ZERO_WORD = 32'h0000_0000;

  // Status field positions
  localparam int STATUS_BUSY_BIT = 0;
  localparam int STATUS_DONE_BIT = 1;
  localparam int STATUS_SHUTDOWN_BIT = 2;
  localparam int STATUS_FAULT_LSB = 4;

  // Stack arithmetic
  localparam logic [31:0] STEP_DWORD = 32'h0000_0004;
  localparam logic [31:0] STEP_WORD = 32'h0000_0002;
  localparam logic [31:0] ONE_WORD = 32'h0000_0001;
  localparam logic [31:0] REAL_SHUTDOWN_SP_A = 32'h0000_0001;
  localparam logic [31:0] REAL_SHUTDOWN_SP_B = 32'h0000_0003;
  localparam logic [31:0] REAL_SHUTDOWN_SP_C = 32'h0000_0005;
  localparam logic [2:0] SAVED_SP_SLOT = 3'h4;
  localparam logic [2:0] LAST_SLOT = 3'h7;
  localparam logic [1:0] IO_PRIVILEGE_LEVEL_FULL = 2'h3;
  localparam logic [1:0] CPL_USER = 2'h3;

  // AXI responses
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  typedef enum logic [2:0] {OP_PUSH_VALUE, OP_PUSH_MEM, OP_PUSH_SP, OP_PUSH_ALL, OP_FLAGS_POP} op_kind_t;
  typedef enum logic [1:0] {MODE_REAL, MODE_PROT, MODE_V86} cpu_mode_t;
  typedef enum logic [2:0] {FAULT_NONE, FAULT_GP, FAULT_SS, FAULT_PF, FAULT_AC} fault_t;
  typedef enum logic [2:0] {ST_IDLE, ST_CHECK, ST_STEP, ST_WAIT, ST_FINISH} exec_state_t;

  // Control register layout, start in bit 0
  typedef struct packed {
    logic [14:0] reserved;
    logic mem_in_stack_seg;
    logic mem_base_is_sp;
    logic null_selector;
    logic size_override;
    logic align_check_en;
    logic [1:0] io_privilege_level;
    logic [1:0] cpl;
    cpu_mode_t mode;
    logic addr32;
    logic op32;
    op_kind_t kind;
    logic start;
  } ctrl_t;

  // Stack store request toward memory
  typedef struct packed {
    logic [31:0] addr;
    logic [31:0] data;
    logic dword;
  } store_req_t;

endpackage : stack_push_pkg

// File: stack_push_props.sv
`timescale 1ns/1ps
`default_nettype none
module stack_push_props
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic awvalid,
  input wire logic wvalid,
  input wire logic awready,
  input wire logic [1:0] bresp,
  input wire logic bvalid,
  input wire logic bready,
  input wire logic arvalid,
  input wire logic arready,
  input wire logic [31:0] rdata,
  input wire logic rvalid,
  input wire logic rready,
  input wire logic st_valid,
  input wire logic st_ready,
  input wire stack_push_pkg::store_req_t st_req,
  input wire logic busy,
  input wire logic shutdown,
  input wire stack_push_pkg::fault_t fault
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  logic prev_ok;
  logic prev_dw;
  logic [31:0] prev_addr;
  // Last accepted store of the running instruction; cleared when idle
  always_ff @(posedge aclk)
  begin
    if (!aresetn || !busy)
      prev_ok <= 1'b0;
    else if (st_valid && st_ready)
      prev_ok <= 1'b1;
    if (st_valid && st_ready)
    begin
      prev_addr <= st_req.addr;
      prev_dw <= st_req.dword;
    end
  end
  sequence store_taken;
    st_valid && st_ready;
  endsequence
  sequence store_next;
    $rose(st_valid) && prev_ok;
  endsequence
  sequence wr_taken;
    awvalid && wvalid && awready;
  endsequence
  store_hold_a: assert property (st_valid && !st_ready |=> st_valid && $stable(st_req))
    else $error("store request changed before accept");
  store_drop_a: assert property (store_taken |=> !st_valid)
    else $error("store request not dropped after accept");
  idle_quiet_a: assert property (!busy |-> !st_valid)
    else $error("store request while idle");
  step_size_a: assert property (store_next |-> st_req.addr == prev_addr -
    (prev_dw ? stack_push_pkg::STEP_DWORD : stack_push_pkg::STEP_WORD))
    else $error("stack step between stores wrong");
  halt_quiet_a: assert property ($rose(shutdown) |-> !st_valid [*3])
    else $error("store after shutdown");
  halt_clean_a: assert property (shutdown |-> fault == stack_push_pkg::FAULT_NONE)
    else $error("fault reported with shutdown");
  wr_answer_a: assert property (wr_taken |=> bvalid)
    else $error("write response late");
  bresp_hold_a: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
    else $error("write response dropped");
  rd_answer_a: assert property (arvalid && arready |=> rvalid)
    else $error("read response late");
  rdata_hold_a: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
    else $error("read data dropped");
endmodule : stack_push_props
bind stack_push_execution_unit stack_push_props i_props (.aclk(aclk), .aresetn(aresetn), .awvalid(awvalid),
  .wvalid(wvalid), .awready(awready), .bresp(bresp), .bvalid(bvalid), .bready(bready), .arvalid(arvalid),
  .arready(arready), .rdata(rdata), .rvalid(rvalid), .rready(rready), .st_valid(st_valid), .st_ready(st_ready),
  .st_req(st_req), .busy(busy), .shutdown(shutdown), .fault(fault));
`default_nettype wire

// File: tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic aclk, aresetn, ce, awvalid, wvalid, bready, arvalid, rready, st_valid, st_ready, st_page_fault;
  logic awready, wready, bvalid, arready, rvalid, busy, shutdown, pf_arm;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata, st_fault_code, st, rv;
  logic [3:0] wstrb, stall;
  logic [1:0] bresp, rresp, rsp;
  stack_push_pkg::store_req_t st_req;
  stack_push_pkg::fault_t fault;
  int errors, checks_done, cycles;
  localparam logic [31:0] BASE = 32'h0000_1000;
  localparam logic [31:0] PF_CODE = 32'h0000_0007;
  stack_push_execution_unit i_stack_push_execution_unit (.aclk(aclk), .aresetn(aresetn), .ce(ce), .awaddr(awaddr),
    .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready),
    .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready), .st_valid(st_valid), .st_ready(st_ready),
    .st_req(st_req), .st_page_fault(st_page_fault), .st_fault_code(st_fault_code), .busy(busy),
    .shutdown(shutdown), .fault(fault));
  stack_mem_model #(.PF_CODE(PF_CODE)) mem (.aclk(aclk), .aresetn(aresetn), .st_valid(st_valid), .st_req(st_req),
    .st_ready(st_ready), .st_page_fault(st_page_fault), .st_fault_code(st_fault_code), .stall(stall),
    .pf_arm(pf_arm));
  // Clock and a hang limit far above the expected run
  initial
  begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end
  always @(posedge aclk)
  begin
    cycles++;
    if (cycles == 30000)
    begin
      errors++;
      conclude();
    end
  end
  task automatic conclude();
    $display("Checks %0d, mismatches %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : conclude
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check
  // Bus cycles; ready is looked at mid-cycle, so it is the value sampled at the next edge
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge aclk);
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    @(negedge aclk);
    while (!awready) @(negedge aclk);
    @(posedge aclk);
    awvalid <= 1'b0;
    wvalid <= 1'b0;
    bready <= 1'b1;
    @(negedge aclk);
    while (!bvalid) @(negedge aclk);
    rsp = bresp;
    @(posedge aclk);
    bready <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    @(negedge aclk);
    while (!arready) @(negedge aclk);
    @(posedge aclk);
    arvalid <= 1'b0;
    rready <= 1'b1;
    @(negedge aclk);
    while (!rvalid) @(negedge aclk);
    rv = rdata;
    rsp = rresp;
    @(posedge aclk);
    rready <= 1'b0;
  endtask : rd
  function automatic logic [31:0] ctl(input logic [2:0] k, input logic o32, input logic a32, input logic [1:0] md,
    input logic [1:0] cp, input logic [1:0] io, input logic [4:0] fl);
    ctl = {15'h0000, fl, io, cp, md, a32, o32, k, 1'b1};
  endfunction : ctl
  // One instruction: load pointer, start, poll for done, judge the outcome
  task automatic op(input logic [31:0] c, input logic [31:0] sp, input logic [2:0] ef, input logic [31:0] ext_stack_pointer,
    input int en, input logic eshd);
    int n0;
    n0 = mem.n;
    wr(stack_push_pkg::STACK_PTR_OFFSET, sp);
    wr(stack_push_pkg::CTRL_OFFSET, c);
    st = 32'h0000_0000;
    while (!st[1])
    begin
      rd(stack_push_pkg::STATUS_OFFSET);
      st = rv;
    end
    check(32'(st[6:4]), 32'(ef));
    check(32'(st[2:0]), 32'({eshd, 2'b10}));
    check(32'(fault), 32'(ef));
    check(32'(shutdown), 32'(eshd));
    check(32'(mem.n - n0), 32'(en));
    rd(stack_push_pkg::STACK_PTR_OFFSET);
    check(rv, ext_stack_pointer);
  endtask : op
  task automatic t_regs();
    rd(stack_push_pkg::SS_LIMIT_OFFSET);
    check(rv, stack_push_pkg::LIMIT_RESET);
    rd(8'h30);
    check(32'(rsp), 32'(stack_push_pkg::RESP_SLVERR));
    wr(8'h34, 32'hFFFF_FFFF);
    check(32'(rsp), 32'(stack_push_pkg::RESP_SLVERR));
    wr(stack_push_pkg::SS_BASE_OFFSET, BASE);
    $display("Test registers done");
  endtask : t_regs
  task automatic t_single();
    logic [31:0] spi [3] = '{32'h0000_0100, 32'h0000_0103, 32'h0001_0004};
    logic [31:0] spo [3] = '{32'h0000_00FC, 32'h0000_0101, 32'h0001_0002};
    logic [31:0] ea [3] = '{32'h0000_10FC, 32'h0000_1101, 32'h0000_1002};
    logic [31:0] m;
    for (int i = 0; i < 3; i++)
    begin
      m = (i == 0) ? 32'hFFFF_FFFF : 32'h0000_FFFF;
      wr(stack_push_pkg::SRC_VALUE_OFFSET, 32'hC0DE_0000 + i);
      op(ctl(3'h0, i == 0, i < 2, 2'h1, 2'h0, 2'h0, 5'h00), spi[i], 3'h0, spo[i], 1, 1'b0);
      check(mem.a[mem.n - 1], ea[i]);
      check(mem.d[mem.n - 1] & m, (32'hC0DE_0000 + i) & m);
      check(32'(mem.w[mem.n - 1]), 32'(i == 0));
    end
    op(ctl(3'h2, 1'b1, 1'b0, 2'h1, 2'h3, 2'h0, 5'h00), 32'h0001_0200, 3'h0, 32'h0001_01FC, 1, 1'b0);
    check(mem.d[mem.n - 1], 32'h0000_0200);
    $display("Test single push done");
  endtask : t_single
  task automatic t_memop();
    wr(stack_push_pkg::MEM_DISP_OFFSET, 32'h0000_0010);
    op(ctl(3'h1, 1'b1, 1'b1, 2'h1, 2'h0, 2'h0, 5'h08), 32'h0000_0200, 3'h0, 32'h0000_01FC, 1, 1'b0);
    rd(stack_push_pkg::EA_OUT_OFFSET);
    check(rv, 32'h0000_0210);
    wr(stack_push_pkg::MEM_LIMIT_OFFSET, 32'h0000_0100);
    op(ctl(3'h1, 1'b1, 1'b1, 2'h1, 2'h0, 2'h0, 5'h08), 32'h0000_0200, 3'h1, 32'h0000_0200, 0, 1'b0);
    wr(stack_push_pkg::SS_LIMIT_OFFSET, 32'h0000_0100);
    op(ctl(3'h1, 1'b1, 1'b1, 2'h1, 2'h0, 2'h0, 5'h18), 32'h0000_0200, 3'h2, 32'h0000_0200, 0, 1'b0);
    wr(stack_push_pkg::SS_LIMIT_OFFSET, 32'h0000_FFFF);
    wr(stack_push_pkg::MEM_LIMIT_OFFSET, 32'h0000_FFFF);
    op(ctl(3'h1, 1'b1, 1'b1, 2'h1, 2'h0, 2'h0, 5'h04), 32'h0000_0100, 3'h1, 32'h0000_0100, 0, 1'b0);
    $display("Test memory operand done");
  endtask : t_memop
  task automatic t_all();
    logic [31:0] v;
    logic [31:0] m;
    int n0;
    for (int i = 0; i < 8; i++)
      wr(8'h40 + 8'(4 * i), 32'hA5A5_0000 + i);
    stall <= 4'h2;
    for (int o = 0; o < 2; o++)
    begin
      n0 = mem.n;
      m = o ? 32'hFFFF_FFFF : 32'h0000_FFFF;
      op(ctl(3'h3, o[0], 1'b1, 2'h1, 2'h0, 2'h0, 5'h00), 32'h0000_0100, 3'h0,
        32'h0000_0100 - (o ? 32 : 16), 8, 1'b0);
      for (int i = 0; i < 8; i++)
      begin
        v = (i == 4) ? 32'h0000_0100 : 32'hA5A5_0000 + i;
        check(mem.d[n0 + i] & m, v & m);
        check(mem.a[n0 + i], BASE + 32'h0000_0100 - (o ? 4 : 2) * (i + 1));
      end
    end
    stall <= 4'h0;
    $display("Test push all done");
  endtask : t_all
  task automatic t_real();
    logic [2:0] k [4] = '{3'h0, 3'h3, 3'h3, 3'h3};
    logic [31:0] s [4] = '{32'h0000_0001, 32'h0000_0001, 32'h0000_0003, 32'h0000_0005};
    for (int i = 0; i < 4; i++)
      op(ctl(k[i], 1'b0, 1'b0, 2'h0, 2'h0, 2'h0, 5'h00), s[i], 3'h0, s[i], 0, 1'b1);
    wr(stack_push_pkg::SS_LIMIT_OFFSET, 32'h0000_00FF);
    op(ctl(3'h0, 1'b0, 1'b0, 2'h0, 2'h0, 2'h0, 5'h00), 32'h0000_0200, 3'h2, 32'h0000_0200, 0, 1'b0);
    op(ctl(3'h0, 1'b0, 1'b0, 2'h0, 2'h0, 2'h0, 5'h00), 32'h0000_0080, 3'h0, 32'h0000_007E, 1, 1'b0);
    wr(stack_push_pkg::SS_LIMIT_OFFSET, 32'h0000_FFFF);
    $display("Test real mode done");
  endtask : t_real
  task automatic t_faults();
    op(ctl(3'h4, 1'b1, 1'b1, 2'h2, 2'h0, 2'h2, 5'h00), 32'h0000_0100, 3'h1, 32'h0000_0100, 0, 1'b0);
    op(ctl(3'h4, 1'b1, 1'b1, 2'h2, 2'h0, 2'h3, 5'h02), 32'h0000_0100, 3'h1, 32'h0000_0100, 0, 1'b0);
    op(ctl(3'h4, 1'b1, 1'b1, 2'h2, 2'h0, 2'h3, 5'h00), 32'h0000_0100, 3'h0, 32'h0000_0100, 0, 1'b0);
    op(ctl(3'h4, 1'b1, 1'b1, 2'h1, 2'h0, 2'h0, 5'h00), 32'h0001_0000, 3'h2, 32'h0001_0000, 0, 1'b0);
    op(ctl(3'h0, 1'b1, 1'b1, 2'h1, 2'h3, 2'h0, 5'h01), 32'h0000_0103, 3'h4, 32'h0000_0103, 0, 1'b0);
    op(ctl(3'h0, 1'b1, 1'b1, 2'h1, 2'h0, 2'h0, 5'h01), 32'h0000_0103, 3'h0, 32'h0000_00FF, 1, 1'b0);
    op(ctl(3'h0, 1'b1, 1'b1, 2'h1, 2'h3, 2'h0, 5'h00), 32'h0000_0103, 3'h0, 32'h0000_00FF, 1, 1'b0);
    pf_arm <= 1'b1;
    for (int md = 1; md < 3; md++)
    begin
      op(ctl(3'h0, 1'b1, 1'b1, md[1:0], 2'h0, 2'h3, 5'h00), 32'h0000_0100, 3'h3, 32'h0000_0100, 0, 1'b0);
      rd(stack_push_pkg::ERR_CODE_OFFSET);
      check(rv, PF_CODE);
    end
    pf_arm <= 1'b0;
    $display("Test faults done");
  endtask : t_faults
  // Inputs settle at time zero; reset covers two edges
  initial
  begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready, pf_arm} = 7'h00;
    ce = 1'b1;
    awaddr = 8'h00;
    araddr = 8'h00;
    wdata = 32'h0000_0000;
    wstrb = 4'hF;
    stall = 4'h0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    t_regs();
    t_single();
    t_memop();
    t_all();
    t_real();
    t_faults();
    conclude();
  end
endmodule : tb
`default_nettype wire
